// ### rtl/cslk_pkg.sv
// Contract
// - hardware stack holds thirty-two sixteen-bit return address entries.
// - call, return, interrupt return and interrupt service use the stack automatically.
// - push, pop and interrupt-variant pop give software explicit stack access.
// - any reset sets the stack index to 1fh.
// - call, push, vectoring increment the index first, then write the selected entry.
// - return, interrupt return, pop, interrupt pop read the entry, then decrement.
// - password is the sixteen program words at 0010h through 001fh.
// - power-on reset sets the lock bit to one.
// - locked with non-blank password denies utility access until a match.
// - cleared lock bit grants utility access with no password check.
// - mass erase leaves the password region all ones.
// - mass erase is allowed without a matching password.
// - every reset starts execution in utility rom at 8000h.
// - utility code branches to application at 0000h or to a loader.
// - fetch and execute complete in one cycle, no pipeline.
// - instructions are fixed sixteen-bit words.
// - three data pointers auto increment or decrement after an access.
// - sixteen accumulators work with the stack for fast calls and switching.
// - utility rom occupies a 4k word block.
`default_nettype none
package cslk_pkg;
    localparam int WORD_W = 16;
    localparam int STACK_DEPTH = 32;
    localparam int IDX_W = 5;
    localparam logic [4:0] STACK_TOP_RESET = 5'h1f;
    localparam logic [15:0] UROM_START = 16'h8000;
    localparam logic [15:0] APP_START = 16'h0000;
    localparam int UROM_WORDS = 4096;
    localparam logic [15:0] PW_FIRST = 16'h0010;
    localparam logic [15:0] PW_LAST = 16'h001f;
    localparam int PW_WORDS = 16;
    localparam int PW_IDX_W = 4;
    localparam logic [15:0] WORD_ONES = 16'hffff;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam int NUM_ACC = 16;
    localparam int NUM_DP = 3;
    localparam int DP_IDX_W = 2;
    typedef enum logic [2:0] {
        CSLK_OP_NONE, CSLK_OP_CALL, CSLK_OP_PUSH, CSLK_OP_VECTOR,
        CSLK_OP_RET, CSLK_OP_RETURN_FROM_INTERRUPT, CSLK_OP_POP, CSLK_OP_POP_INTERRUPT_VARIANT
    } cslk_op_type;
endpackage
`default_nettype wire

// ### rtl/cslk_core_stack_and_code_lock.sv
`timescale 1ns/1ps
`default_nettype none
module cslk_core_stack_and_code_lock (
    input wire logic i_mclk, // 50 mhz clock
    input wire logic i_rst, // sync reset, high
    input wire logic i_por, // power-on reset pulse, high
    input wire cslk_pkg::cslk_op_type i_op, // stack operation this cycle
    input wire logic [15:0] i_push_data, // value to push
    output logic [15:0] o_pop_data, // value popped, registered
    output logic o_pop_valid, // pop result valid, one cycle
    output logic [4:0] o_stack_top_index, // current stack index
    input wire logic i_dp_access, // data pointer access strobe
    input wire logic [1:0] i_dp_sel, // which data pointer
    input wire logic i_dp_dec, // 1 decrement, 0 increment
    input wire logic i_dp_load, // load pointer
    input wire logic [15:0] i_dp_load_val, // load value
    output logic [15:0] o_dp0, // data pointer 0
    output logic [15:0] o_dp1, // data pointer 1
    output logic [15:0] o_dp2, // data pointer 2
    input wire logic i_acc_we, // accumulator write
    input wire logic [3:0] i_acc_sel, // accumulator index
    input wire logic [15:0] i_acc_wdata, // accumulator data
    output logic [15:0] o_acc_rdata, // selected accumulator, registered
    input wire logic i_pw_load, // store a password word from memory
    input wire logic [15:0] i_pw_addr, // program address of that word
    input wire logic [15:0] i_pw_data, // program word
    input wire logic i_key_valid, // supplied key word strobe
    input wire logic [3:0] i_key_idx, // supplied key word index
    input wire logic [15:0] i_key_data, // supplied key word
    input wire logic i_key_check, // compare supplied key now
    input wire logic i_lock_clear, // clear lock bit
    input wire logic i_mass_erase, // mass erase request
    input wire logic i_boot_app, // rom decides to start application
    input wire logic i_boot_go, // rom branch decision strobe
    output logic o_utility_access, // utility rom usable
    output logic o_code_lock_bit, // lock bit
    output logic o_mass_erase_ack, // erase accepted, one cycle
    output logic [15:0] o_fetch_pc, // execution start address
    output logic o_fetch_load // load pc, one cycle
);
    import cslk_pkg::*;

    // ====================================================
    // stack
    logic [15:0] stack_mem [STACK_DEPTH];
    logic [4:0] stack_top_index;
    logic is_push, is_pop;
    assign is_push = (i_op == CSLK_OP_CALL) || (i_op == CSLK_OP_PUSH) ||
                     (i_op == CSLK_OP_VECTOR);
    assign is_pop = (i_op == CSLK_OP_RET) || (i_op == CSLK_OP_RETURN_FROM_INTERRUPT) ||
                    (i_op == CSLK_OP_POP) || (i_op == CSLK_OP_POP_INTERRUPT_VARIANT);

    always_ff @(posedge i_mclk) begin
        if (i_rst || i_por) begin
            stack_top_index <= STACK_TOP_RESET;
        end else if (is_push) begin
            stack_top_index <= stack_top_index + 5'h01;
        end else if (is_pop) begin
            stack_top_index <= stack_top_index - 5'h01;
        end
    end

    // no reset on the array: contents are undefined after reset, as in the core
    always_ff @(posedge i_mclk) begin
        if (is_push && !(i_rst || i_por)) begin
            stack_mem[stack_top_index + 5'h01] <= i_push_data;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst || i_por) begin
            o_pop_data <= WORD_ZERO;
            o_pop_valid <= 1'b0;
        end else begin
            o_pop_valid <= is_pop;
            if (is_pop) begin
                o_pop_data <= stack_mem[stack_top_index];
            end
        end
    end
    assign o_stack_top_index = stack_top_index;

    // ====================================================
    // data pointers
    logic [15:0] dp [NUM_DP];
    always_ff @(posedge i_mclk) begin
        if (i_rst || i_por) begin
            for (int k = 0; k < NUM_DP; k++) begin
                dp[k] <= WORD_ZERO;
            end
        end else if (i_dp_sel < 2'(NUM_DP)) begin
            if (i_dp_load) begin
                dp[i_dp_sel] <= i_dp_load_val;
            end else if (i_dp_access) begin
                dp[i_dp_sel] <= i_dp_dec ? dp[i_dp_sel] - 16'h0001
                                         : dp[i_dp_sel] + 16'h0001;
            end
        end
    end
    assign o_dp0 = dp[0];
    assign o_dp1 = dp[1];
    assign o_dp2 = dp[2];

    // ====================================================
    // accumulators, single-cycle write and read
    logic [15:0] acc [NUM_ACC];
    always_ff @(posedge i_mclk) begin
        if (i_acc_we) begin
            acc[i_acc_sel] <= i_acc_wdata;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_rst || i_por) begin
            o_acc_rdata <= WORD_ZERO;
        end else begin
            o_acc_rdata <= i_acc_we ? i_acc_wdata : acc[i_acc_sel];
        end
    end

    // ====================================================
    // password lock
    logic [15:0] pw_word [PW_WORDS];
    logic [15:0] key_word [PW_WORDS];
    logic code_lock_bit;
    logic unlocked;
    logic pw_blank;

    function automatic logic in_pw_region(input logic [15:0] a);
        return (a >= PW_FIRST) && (a <= PW_LAST);
    endfunction

    always_comb begin
        logic all_ones, all_zero;
        all_ones = 1'b1;
        all_zero = 1'b1;
        for (int k = 0; k < PW_WORDS; k++) begin
            all_ones &= (pw_word[k] == WORD_ONES);
            all_zero &= (pw_word[k] == WORD_ZERO);
        end
        pw_blank = all_ones || all_zero;
    end

    logic key_match;
    always_comb begin
        key_match = 1'b1;
        for (int k = 0; k < PW_WORDS; k++) begin
            key_match &= (key_word[k] == pw_word[k]);
        end
    end

    // erase is never gated by the lock so a locked part can be recovered
    always_ff @(posedge i_mclk) begin
        if (i_por || i_mass_erase) begin
            for (int k = 0; k < PW_WORDS; k++) begin
                pw_word[k] <= WORD_ONES;
            end
        end else if (i_pw_load && in_pw_region(i_pw_addr)) begin
            pw_word[i_pw_addr[3:0]] <= i_pw_data;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst || i_por) begin
            for (int k = 0; k < PW_WORDS; k++) begin
                key_word[k] <= WORD_ZERO;
            end
        end else if (i_key_valid) begin
            key_word[i_key_idx] <= i_key_data;
        end
    end

    // the lock bit only returns to one on power-on, not on other resets
    always_ff @(posedge i_mclk) begin
        if (i_por) begin
            code_lock_bit <= 1'b1;
        end else if (i_lock_clear) begin
            code_lock_bit <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst || i_por || i_mass_erase) begin
            unlocked <= 1'b0;
        end else if (i_key_check) begin
            unlocked <= key_match;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst || i_por) begin
            o_mass_erase_ack <= 1'b0;
        end else begin
            o_mass_erase_ack <= i_mass_erase;
        end
    end

    assign o_code_lock_bit = code_lock_bit;
    assign o_utility_access = !code_lock_bit || pw_blank || unlocked;

    // ====================================================
    // reset entry and rom dispatch
    always_ff @(posedge i_mclk) begin
        if (i_rst || i_por) begin
            o_fetch_pc <= UROM_START;
            o_fetch_load <= 1'b1;
        end else if (i_boot_go) begin
            o_fetch_pc <= i_boot_app ? APP_START : UROM_START + 16'(UROM_WORDS);
            o_fetch_load <= 1'b1;
        end else begin
            o_fetch_load <= 1'b0;
        end
    end

    // ====================================================
    // checks: stack
    a_reset_top: assert property (@(posedge i_mclk)
        (i_rst || i_por) |=> (stack_top_index == STACK_TOP_RESET))
        else $error("stack index not 1f after reset");
    a_push_incr: assert property (@(posedge i_mclk) disable iff (i_rst || i_por)
        is_push |=> (stack_top_index == $past(stack_top_index) + 5'h01))
        else $error("push did not increment index");
    a_pop_decr: assert property (@(posedge i_mclk) disable iff (i_rst || i_por)
        is_pop |=> (stack_top_index == $past(stack_top_index) - 5'h01))
        else $error("pop did not decrement index");
    // any pop right after any push must hand back the word just pushed
    a_push_pop_data: assert property (@(posedge i_mclk) disable iff (i_rst || i_por)
        (is_push ##1 is_pop) |=> (o_pop_data == $past(i_push_data, 2)))
        else $error("pop did not return pushed word");
    a_pop_valid_pulse: assert property (@(posedge i_mclk) disable iff (i_rst || i_por)
        !is_pop |=> !o_pop_valid)
        else $error("pop valid without a pop");
    a_index_hold: assert property (@(posedge i_mclk) disable iff (i_rst || i_por)
        (i_op == CSLK_OP_NONE) |=> $stable(stack_top_index))
        else $error("index moved without an op");
    a_wrap_top: assert property (@(posedge i_mclk) disable iff (i_rst || i_por)
        (is_push && stack_top_index == STACK_TOP_RESET) |=> (stack_top_index == 5'h00))
        else $error("index did not wrap");
    c_push_pop: cover property (@(posedge i_mclk) is_push ##1 is_pop);
    c_wrap_push: cover property (@(posedge i_mclk) is_push && stack_top_index == STACK_TOP_RESET);

    // ====================================================
    // checks: pointers and accumulators
    a_dp_up: assert property (@(posedge i_mclk) disable iff (i_rst || i_por)
        (i_dp_access && !i_dp_load && !i_dp_dec && i_dp_sel == 2'h0)
            |=> (o_dp0 == $past(o_dp0) + 16'h0001))
        else $error("pointer did not step up");
    a_dp_down: assert property (@(posedge i_mclk) disable iff (i_rst || i_por)
        (i_dp_access && !i_dp_load && i_dp_dec && i_dp_sel == 2'h1)
            |=> (o_dp1 == $past(o_dp1) - 16'h0001))
        else $error("pointer did not step down");
    // write-through: reading the word being written returns the new value
    a_acc_through: assert property (@(posedge i_mclk) disable iff (i_rst || i_por)
        i_acc_we |=> (o_acc_rdata == $past(i_acc_wdata)))
        else $error("accumulator write not seen next cycle");

    // ====================================================
    // checks: lock
    a_por_lock: assert property (@(posedge i_mclk)
        i_por |=> o_code_lock_bit)
        else $error("lock bit not set by power-on");
    // a warm reset must not touch the lock, only power-on sets it again
    a_lock_warm: assert property (@(posedge i_mclk)
        (i_rst && !i_por && !i_lock_clear) |=> $stable(o_code_lock_bit))
        else $error("warm reset changed the lock bit");
    a_unlocked_access: assert property (@(posedge i_mclk)
        !o_code_lock_bit |-> o_utility_access)
        else $error("access denied with lock clear");
    a_erase_blank: assert property (@(posedge i_mclk) disable iff (i_por)
        (i_mass_erase && !i_rst) |=> (pw_blank && o_mass_erase_ack))
        else $error("erase left password non blank");
    a_erase_pulse: assert property (@(posedge i_mclk)
        !i_mass_erase |=> !o_mass_erase_ack)
        else $error("erase ack without a request");
    // a failed check while locked leaves access to a blank password only
    a_locked_deny: assert property (@(posedge i_mclk)
        (i_key_check && !key_match && o_code_lock_bit && !i_lock_clear)
            |=> (pw_blank || !o_utility_access))
        else $error("locked part gave access");
    a_key_unlock: assert property (@(posedge i_mclk)
        (i_key_check && key_match && !i_rst && !i_por && !i_mass_erase) |=> o_utility_access)
        else $error("matching key did not unlock");
    c_unlock: cover property (@(posedge i_mclk) o_code_lock_bit && unlocked && !pw_blank);
    c_erase_locked: cover property (@(posedge i_mclk) i_mass_erase && o_code_lock_bit && !pw_blank);

    // ====================================================
    // checks: reset entry and dispatch
    a_reset_vector: assert property (@(posedge i_mclk)
        i_rst |=> (o_fetch_load && o_fetch_pc == UROM_START))
        else $error("reset did not enter utility rom");
    // the load strobe is one cycle wide so the fetch unit jumps once per decision
    a_load_drop: assert property (@(posedge i_mclk)
        (!i_rst && !i_por && !i_boot_go) |=> !o_fetch_load)
        else $error("fetch load held without a decision");
    a_boot_app: assert property (@(posedge i_mclk)
        (i_boot_go && i_boot_app && !i_rst && !i_por) |=> (o_fetch_pc == APP_START))
        else $error("application start not taken");
    a_boot_loader: assert property (@(posedge i_mclk)
        (i_boot_go && !i_boot_app && !i_rst && !i_por)
            |=> (o_fetch_pc == UROM_START + 16'(UROM_WORDS)))
        else $error("loader start not taken");
    c_boot_app: cover property (@(posedge i_mclk) i_boot_go && i_boot_app);
endmodule // cslk_core_stack_and_code_lock
`default_nettype wire

// ### verif/cslk_core_stack_and_code_lock_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cslk_core_stack_and_code_lock_tb;
    import cslk_pkg::*;
    logic i_mclk, i_rst, i_por, o_pop_valid, i_dp_access, i_dp_dec, i_dp_load, i_acc_we;
    logic i_pw_load, i_key_valid, i_key_check, i_lock_clear, i_mass_erase, i_boot_app, i_boot_go;
    logic o_utility_access, o_code_lock_bit, o_mass_erase_ack, o_fetch_load;
    cslk_op_type i_op;
    logic [15:0] i_push_data, o_pop_data, i_dp_load_val, o_dp0, o_dp1, o_dp2, i_acc_wdata;
    logic [15:0] o_acc_rdata, i_pw_addr, i_pw_data, i_key_data, o_fetch_pc;
    logic [4:0] o_stack_top_index;
    logic [3:0] i_acc_sel, i_key_idx;
    logic [1:0] i_dp_sel;
    int bad_count = 0;
    int num_checks = 0;

    cslk_core_stack_and_code_lock dut_u (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_por(i_por), .i_op(i_op), .i_push_data(i_push_data),
        .o_pop_data(o_pop_data), .o_pop_valid(o_pop_valid), .o_stack_top_index(o_stack_top_index),
        .i_dp_access(i_dp_access), .i_dp_sel(i_dp_sel), .i_dp_dec(i_dp_dec), .i_dp_load(i_dp_load),
        .i_dp_load_val(i_dp_load_val), .o_dp0(o_dp0), .o_dp1(o_dp1), .o_dp2(o_dp2),
        .i_acc_we(i_acc_we), .i_acc_sel(i_acc_sel), .i_acc_wdata(i_acc_wdata),
        .o_acc_rdata(o_acc_rdata), .i_pw_load(i_pw_load), .i_pw_addr(i_pw_addr),
        .i_pw_data(i_pw_data), .i_key_valid(i_key_valid), .i_key_idx(i_key_idx),
        .i_key_data(i_key_data), .i_key_check(i_key_check), .i_lock_clear(i_lock_clear),
        .i_mass_erase(i_mass_erase), .i_boot_app(i_boot_app), .i_boot_go(i_boot_go),
        .o_utility_access(o_utility_access), .o_code_lock_bit(o_code_lock_bit),
        .o_mass_erase_ack(o_mass_erase_ack), .o_fetch_pc(o_fetch_pc), .o_fetch_load(o_fetch_load)
    );

    // ==========================================================
    // clock, helpers and verdict
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end

    // inputs always change 1 ns after the edge, outputs are read there too
    task automatic tick;
        @(posedge i_mclk);
        #1;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask

    task automatic results;
        if (bad_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        i_rst = 1'b1;
        i_por = 1'b1;
        repeat (16) tick();
        chk("index", 16'(STACK_TOP_RESET), 16'(o_stack_top_index));
        chk("lock bit", 16'h0001, 16'(o_code_lock_bit));
        chk("start pc", UROM_START, o_fetch_pc);
        chk("pc load", 16'h0001, 16'(o_fetch_load));
        i_rst = 1'b0;
        i_por = 1'b0;
        tick();
        chk("blank access", 16'h0001, 16'(o_utility_access));
    endtask

    // four pushes wrap the index past 1f, pops come back in reverse, back to back
    task automatic t_stack;
        cslk_op_type pu[4] = '{CSLK_OP_CALL, CSLK_OP_PUSH, CSLK_OP_VECTOR, CSLK_OP_PUSH};
        cslk_op_type po[4] = '{CSLK_OP_RET, CSLK_OP_RETURN_FROM_INTERRUPT, CSLK_OP_POP,
                               CSLK_OP_POP_INTERRUPT_VARIANT};
        for (int k = 0; k < 4; k++) begin
            i_op = pu[k];
            i_push_data = 16'hc0d0 + 16'(k);
            tick();
            chk("push index", 16'(k), 16'(o_stack_top_index));
        end
        for (int k = 0; k < 4; k++) begin
            i_op = po[k];
            tick();
            chk("pop data", 16'hc0d3 - 16'(k), o_pop_data);
            chk("pop valid", 16'h0001, 16'(o_pop_valid));
        end
        i_op = CSLK_OP_NONE;
        tick();
        chk("idle valid", 16'h0000, 16'(o_pop_valid));
        chk("pop index", 16'h001f, 16'(o_stack_top_index));
    endtask

    task automatic t_regs;
        i_dp_access = 1'b1;
        repeat (2) tick();
        i_dp_sel = 2'h1;
        i_dp_load = 1'b1;
        i_dp_load_val = 16'h0010;
        tick();
        i_dp_load = 1'b0;
        i_dp_dec = 1'b1;
        tick();
        i_dp_sel = 2'h2;
        tick();
        i_dp_access = 1'b0;
        chk("dp0", 16'h0002, o_dp0);
        chk("dp1", 16'h000f, o_dp1);
        chk("dp2", 16'hffff, o_dp2);
        i_acc_we = 1'b1;
        i_acc_sel = 4'h3;
        i_acc_wdata = 16'h1234;
        tick();
        chk("acc through", 16'h1234, o_acc_rdata);
        i_acc_sel = 4'hf;
        i_acc_wdata = 16'h4321;
        tick();
        i_acc_we = 1'b0;
        i_acc_sel = 4'h3;
        tick();
        chk("acc kept", 16'h1234, o_acc_rdata);
    endtask

    task automatic t_boot;
        i_boot_app = 1'b1;
        pulse(i_boot_go);
        chk("app pc", APP_START, o_fetch_pc);
        chk("app load", 16'h0001, 16'(o_fetch_load));
        tick();
        chk("load drop", 16'h0000, 16'(o_fetch_load));
        i_boot_app = 1'b0;
        pulse(i_boot_go);
        chk("loader pc", UROM_START + 16'(UROM_WORDS), o_fetch_pc);
    endtask

    // word 7 of the supplied key differs when bad is set
    task automatic t_pw(input bit keys, input bit bad);
        for (int k = 0; k < PW_WORDS; k++) begin
            i_pw_load = 1'b1;
            i_pw_addr = PW_FIRST + 16'(k);
            i_pw_data = 16'h5a00 + 16'(k);
            i_key_valid = keys;
            i_key_idx = 4'(k);
            i_key_data = 16'h5a00 + 16'(k) + 16'(bad && k == 7);
            tick();
        end
        i_pw_load = 1'b0;
        i_key_valid = 1'b0;
        pulse(i_key_check);
    endtask

    task automatic t_lock;
        t_pw(1'b1, 1'b1);
        chk("bad key", 16'h0000, 16'(o_utility_access));
        pulse(i_mass_erase);
        chk("erase ack", 16'h0001, 16'(o_mass_erase_ack));
        chk("erased access", 16'h0001, 16'(o_utility_access));
        t_pw(1'b1, 1'b0);
        chk("good key", 16'h0001, 16'(o_utility_access));
        pulse(i_rst);
        chk("warm index", 16'h001f, 16'(o_stack_top_index));
        chk("warm lock", 16'h0001, 16'(o_code_lock_bit));
        chk("warm deny", 16'h0000, 16'(o_utility_access));
        chk("warm pc", UROM_START, o_fetch_pc);
        pulse(i_lock_clear);
        chk("clear access", 16'h0001, 16'(o_utility_access));
        pulse(i_rst);
        chk("lock kept", 16'h0000, 16'(o_code_lock_bit));
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        {i_rst, i_por, i_dp_access, i_dp_dec, i_dp_load, i_acc_we, i_pw_load} = '0;
        {i_key_valid, i_key_check, i_lock_clear, i_mass_erase, i_boot_app, i_boot_go} = '0;
        {i_push_data, i_dp_load_val, i_acc_wdata, i_pw_addr, i_pw_data, i_key_data} = '0;
        {i_acc_sel, i_key_idx, i_dp_sel} = '0;
        i_op = CSLK_OP_NONE;
        t_reset();
        t_stack();
        t_regs();
        t_boot();
        t_lock();
        results();
    end

    // the whole run needs about 75 cycles
    initial begin
        repeat (3000) @(posedge i_mclk);
        bad_count++;
        results();
    end
endmodule // cslk_core_stack_and_code_lock_tb
`default_nettype wire
